// ===== rtl/dpw_pkg.sv
// Timing and encoding constants for the dual-port memory port controller
package dpw_pkg;
    localparam int CLK_NS = 10;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int SYNC_LAT = 2;
    // Slowest speed grade figures, in ns
    localparam int T_WP_NS = 55;
    localparam int T_WZ_NS = 40;
    localparam int T_DW_NS = 40;
    localparam int T_WH_NS = 20;
    localparam int T_AA_NS = 100;
    localparam int T_BDD_NS = 65;
    localparam int T_HZ_NS = 40;
    // Least times round up to whole cycles
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WZDW_CYC = (T_WZ_NS + T_DW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPW_CYC = (WP_CYC > WZDW_CYC) ? WP_CYC : WZDW_CYC;
    localparam int WH_CYC = (T_WH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC = (T_AA_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
    localparam int BDD_CYC = (T_BDD_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
    localparam int HZ_CYC = (T_HZ_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b011,
        ST_RECOV = 3'b100
    } dpw_state_e;
endpackage

// ===== rtl/dpw_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dpw_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] async_i,
    input wire logic [W-1:0] rst_val_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            meta_q <= rst_val_i;
            sync_o <= rst_val_i;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // dpw_sync

// ===== rtl/dpw_port_ctrl.sv
// Host-side controller for one port of an asynchronous dual-port memory
//
// Overview of operation
// - Address changes only with select deasserted
// - Strobe lasts max(pulse, turnoff plus setup)
// - Slave busy asserted before losing strobe starts
// - Hold strobe write-hold time after busy release
`timescale 1ns/1ps
module dpw_port_ctrl
    import dpw_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // User request side
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic inhibit_i,
    output logic ack_o,
    output logic busy_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic mail_o,
    output logic was_blocked_o,
    // Memory port pins
    output logic ce_n_o,
    output logic rw_n_o,
    output logic oe_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic busy_n_i,
    input wire logic mail_flag_n_i,
    output logic slave_busy_n_o
);
    dpw_state_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic we_q;
    logic busy_s;
    logic mail_n_s;
    logic [DATA_W-1:0] data_s;

    dpw_sync #(.W(DATA_W + 2)) u_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .async_i({busy_n_i, mail_flag_n_i, data_i}),
        .rst_val_i({2'b11, DATA_RST}),
        .sync_o({busy_s, mail_n_s, data_s})
    );

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n);
    endfunction

    // Select and strobe end together once the count runs out with busy clear
    function automatic logic strobe_end(input dpw_state_e st, input logic [CNT_W-1:0] cnt, input logic bsy);
        return (st == ST_WRITE || st == ST_READ) && (cnt == '0) && bsy;
    endfunction

    // Sequencer
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            we_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_i) begin
                        we_q <= we_i;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Address settles one cycle before select falls
                    cnt_q <= we_q ? cyc(WPW_CYC) : cyc(RD_CYC);
                    state_q <= we_q ? ST_WRITE : ST_READ;
                end
                ST_WRITE: begin
                    // Busy seen: keep strobe low, hold time counted after release
                    if (!busy_s) begin
                        cnt_q <= (cnt_q > cyc(WH_CYC)) ? cnt_q : cyc(WH_CYC);
                    end else if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        cnt_q <= '0;
                        state_q <= ST_RECOV;
                    end
                end
                ST_READ: begin
                    // Data is only valid a settle time after busy clears
                    if (!busy_s) begin
                        cnt_q <= cyc(BDD_CYC);
                    end else if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        cnt_q <= cyc(HZ_CYC);
                        state_q <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Address and write data load only while select is high
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            addr_o <= ADDR_RST;
            data_o <= DATA_RST;
        end else if (state_q == ST_IDLE && req_i) begin
            addr_o <= addr_i;
            data_o <= wdata_i;
        end
    end

    // Select and strobe fall together; output enable stays high on writes so the memory never drives
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ce_n_o <= 1'b1;
            rw_n_o <= 1'b1;
            oe_n_o <= 1'b1;
        end else if (state_q == ST_SETUP) begin
            ce_n_o <= 1'b0;
            rw_n_o <= !we_q;
            oe_n_o <= we_q;
        end else if (strobe_end(state_q, cnt_q, busy_s)) begin
            ce_n_o <= 1'b1;
            rw_n_o <= 1'b1;
            oe_n_o <= 1'b1;
        end
    end

    // Data held one cycle past strobe end for hold margin
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            data_oe_o <= 1'b0;
        end else if (state_q == ST_SETUP) begin
            data_oe_o <= we_q;
        end else if (state_q == ST_RECOV) begin
            data_oe_o <= 1'b0;
        end
    end

    // Slave inhibit is latched before the strobe can fall
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            slave_busy_n_o <= 1'b1;
        end else if (state_q == ST_IDLE && req_i) begin
            slave_busy_n_o <= !inhibit_i;
        end else if (state_q == ST_IDLE) begin
            slave_busy_n_o <= 1'b1;
        end
    end

    // Completion pulse, one cycle
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= (state_q == ST_RECOV) && (cnt_q == '0);
        end
    end

    // Also high while a request waits in idle, so the user never double issues
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_q != ST_IDLE) || req_i;
        end
    end

    // Mail flag level
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            mail_o <= 1'b0;
        end else begin
            mail_o <= !mail_n_s;
        end
    end

    // Read data taken once the access count, or the settle count after busy release, runs out
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rdata_o <= DATA_RST;
        end else if (state_q == ST_READ && strobe_end(state_q, cnt_q, busy_s)) begin
            rdata_o <= data_s;
        end
    end

    // Busy seen during the current access
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            was_blocked_o <= 1'b0;
        end else if (state_q == ST_SETUP) begin
            was_blocked_o <= 1'b0;
        end else if ((state_q == ST_WRITE || state_q == ST_READ) && !busy_s) begin
            was_blocked_o <= 1'b1;
        end
    end
endmodule // dpw_port_ctrl

// ===== verif/dpw_port_ctrl_assertions.sv
// Pin timing checker for the memory port controller
`timescale 1ns/1ps
module dpw_port_ctrl_assertions
    import dpw_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Watched ports
    input wire logic ce_n_o,
    input wire logic rw_n_o,
    input wire logic oe_n_o,
    input wire logic [ADDR_W-1:0] addr_o,
    input wire logic data_oe_o,
    input wire logic busy_n_i,
    input wire logic slave_busy_n_o,
    input wire logic ack_o,
    input wire logic busy_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    AST_ADDR_HELD: assert property (!ce_n_o || !rw_n_o |-> $stable(addr_o)) else $error("address moved");
    AST_PULSE_WIDTH: assert property ($fell(rw_n_o) |-> !rw_n_o [*8]) else $error("strobe too short");
    AST_WRITE_PINS: assert property (!rw_n_o |-> data_oe_o && oe_n_o && !ce_n_o) else $error("write pins");
    AST_INHIBIT_LEAD: assert property ($fell(slave_busy_n_o) |=> $fell(ce_n_o) && !slave_busy_n_o) else $error("inhibit late");
    AST_HOLD_AFTER: assert property ($rose(busy_n_i) && !rw_n_o |-> !rw_n_o [*3]) else $error("hold short");
    AST_ACK_END: assert property (ack_o |-> ce_n_o && rw_n_o ##1 !ack_o && !busy_o) else $error("ack shape");
endmodule // dpw_port_ctrl_assertions

bind dpw_port_ctrl dpw_port_ctrl_assertions u_chk (.clk_sys_i, .resetn_i, .ce_n_o, .rw_n_o, .oe_n_o, .addr_o,
    .data_oe_o, .busy_n_i, .slave_busy_n_o, .ack_o, .busy_o);

// ===== verif/dpw_mem_model.sv
// Behavioural memory port with busy and mail flag
`timescale 1ns/1ps
module dpw_mem_model (
    // Pins from the controller
    input wire logic ce_n_i,
    input wire logic rw_n_i,
    input wire logic oe_n_i,
    input wire logic [9:0] addr_i,
    input wire logic [7:0] wd_i,
    // Far port activity
    input wire logic peer_busy_i,
    input wire logic peer_mail_i,
    // Pins to the controller
    output logic [7:0] rd_o,
    output logic busy_n_o,
    output logic flag_n_o
);
    logic [7:0] mem [1024];
    logic [7:0] last = 8'h00;
    logic flag = 1'b1;
    // Far port always wins, so only this side is flagged
    assign busy_n_o = ~peer_busy_i;
    assign flag_n_o = flag;
    // Released bus shows the inverse so stale data cannot pass
    assign rd_o = (!ce_n_i && !oe_n_i && rw_n_i) ? mem[addr_i] : ~last;
    always @* if (!ce_n_i && !oe_n_i && rw_n_i) last = mem[addr_i];
    always @* if (!ce_n_i && !rw_n_i && busy_n_o) mem[addr_i] = wd_i;
    always @* begin
        if (peer_mail_i) flag = 1'b0;
        else if (!ce_n_i && !oe_n_i && addr_i == 10'h3FF && busy_n_o) flag = 1'b1;
    end
endmodule // dpw_mem_model

// ===== verif/dpw_port_ctrl_bench.sv
// Self-checking bench for the memory port controller
`timescale 1ns/1ps
module dpw_port_ctrl_bench;
    import dpw_pkg::*;
    logic clk_sys_i = 0, resetn_i = 0, req = 0, we = 0, inh = 0, pbusy = 0, pmail = 0;
    logic [ADDR_W-1:0] addr = '0, apin;
    logic [DATA_W-1:0] wdata = '0, rdata, rpin, dpin;
    logic ack, busy, mail, blk, ce_n, rw_n, oe_n, busy_n, flag_n, doe, sbusy_n;
    int num_errors = 0, tests_run = 0, cycles = 0, lw, lr;
    dpw_port_ctrl dut (.clk_sys_i, .resetn_i, .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wdata),
        .inhibit_i(inh), .ack_o(ack), .busy_o(busy), .rdata_o(rdata), .mail_o(mail), .was_blocked_o(blk),
        .ce_n_o(ce_n), .rw_n_o(rw_n), .oe_n_o(oe_n), .addr_o(apin), .data_o(dpin), .data_oe_o(doe),
        .data_i(rpin), .busy_n_i(busy_n), .mail_flag_n_i(flag_n), .slave_busy_n_o(sbusy_n));
    dpw_mem_model mem (.ce_n_i(ce_n), .rw_n_i(rw_n), .oe_n_i(oe_n), .addr_i(apin), .wd_i(dpin),
        .peer_busy_i(pbusy), .peer_mail_i(pmail), .rd_o(rpin), .busy_n_o(busy_n), .flag_n_o(flag_n));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // Returns cycles from request to acknowledge
    task automatic access(input logic w, input logic [9:0] a, input logic [7:0] d, output int n);
        @(negedge clk_sys_i);
        req = 1;
        we = w;
        addr = a;
        wdata = d;
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
            req = 0;
        end while (ack !== 1'b1 && n < 300);
    endtask
    task automatic t_rw;
        inh = 1;
        access(1, 10'h155, 8'hA5, lw);
        check(8'(sbusy_n), 8'h00);
        check(8'(lw), 8'(WPW_CYC + 4));
        inh = 0;
        access(0, 10'h155, 8'h00, lr);
        check(rdata, 8'hA5);
        check(8'(lr - lw), 8'(RD_CYC + HZ_CYC - WPW_CYC));
        check(8'(blk), 8'h00);
        check(8'(sbusy_n), 8'h01);
    endtask
    task automatic t_busy;
        pbusy = 1;
        fork
            access(1, 10'h2AA, 8'h5C, lw);
            begin
                repeat (30) @(negedge clk_sys_i);
                check(8'(rw_n), 8'h00);
                check(8'(doe), 8'h01);
                pbusy = 0;
            end
        join
        check(8'(blk), 8'h01);
        check(8'(lw > 30), 8'h01);
        access(0, 10'h2AA, 8'h00, lr);
        check(rdata, 8'h5C);
    endtask
    task automatic t_mail;
        pmail = 1;
        @(negedge clk_sys_i);
        pmail = 0;
        repeat (5) @(negedge clk_sys_i);
        check(8'(mail), 8'h01);
        access(0, 10'h3FF, 8'h00, lr);
        repeat (5) @(negedge clk_sys_i);
        check(8'(mail), 8'h00);
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(negedge clk_sys_i);
        resetn_i = 1;
        t_rw();
        t_busy();
        t_mail();
        give_verdict();
    end
endmodule // dpw_port_ctrl_bench
